// ---- rtl/voice_alarm_params.svh ----
// Constants for the telephone voice alarm sequencer.
// Notes on behaviour
// - High trigger starts a call to stored number.
// - Success sets success, clears failure until trigger low.
// - Failure sets failure, clears success until trigger low.
// - Unanswered calls redial up to the attempt limit.
// - Password call: prompt, confirm, alarm three times.
// - Success reported after twenty second hold.
// - Wrong password: error message, prompt again, limit.
// - After hang-up redial; all attempts failed gives failure.
// - No password: alarm thrice, hold, hang up, success.
// - Remote hang-up: finish message, short delay, hang up.
// - System messages 0 to 4 never used as alarms.
// - Success needs answer plus completed alarm playback.
// - Number ends at colon; no colon means invalid.
// - Dial-in trigger high makes that entry active.
// - Protected dial-in: password loop, confirm, alarm thrice, hold.
// - Unprotected dial-in: alarms thrice, hold, hang up.
// - Mixed: free alarms, password, protected, replay twice.
// - Call with no active entry hears no-alarm message.
// - Message 0 asks for key 0; message 4 no alarm.
`ifndef VOICE_ALARM_PARAMS_SVH
`define VOICE_ALARM_PARAMS_SVH

`define REG_CTRL        8'h00
`define REG_ALARM_MSG   8'h04
`define REG_PASSWORD    8'h08
`define REG_STATUS      8'h0c
`define REG_DIN_CFG     8'h10
`define REG_PHONE_BASE  2'b01

`define CTRL_PW_BIT     0
`define CTRL_ATT_LSB    8
`define CTRL_RING_LSB   12
`define CTRL_WRONG_LSB  16
`define CTRL_RST        32'h0003_5300
`define ALARM_MSG_RST   8'h05
`define PASSWORD_RST    16'h1234
`define DIN_BYTE_RST    8'h05

`define MSG_PRESS0      8'h00
`define MSG_PW_PROMPT   8'h01
`define MSG_PW_OK       8'h02
`define MSG_PW_BAD      8'h03
`define MSG_NO_ALARM    8'h04
`define MSG_FIRST_USER  8'h05

`define KEY_STAR        4'ha
`define KEY_LAST_DIGIT  4'h9
`define PHONE_COLON     8'h3a

`define ALARM_REPS      2'd3
`define REPLAY_REPS     2'd2

`define CLK_HZ          64'd125000000
`define HOLD_TIME_S     64'd20
`define DROP_TIME_S     64'd2

`endif

// ---- rtl/voice_alarm_pkg.sv ----
// Types shared by the voice alarm sequencer.
package voice_alarm_pkg;
	typedef enum logic [3:0] {
		S_IDLE    = 4'b0000,
		S_DIAL    = 4'b0001,
		S_RING    = 4'b0010,
		S_GREET   = 4'b0011,
		S_PROMPT  = 4'b0100,
		S_GETPW   = 4'b0101,
		S_PWBAD   = 4'b0110,
		S_PWOK    = 4'b0111,
		S_PLAY    = 4'b1000,
		S_HOLD    = 4'b1001,
		S_END     = 4'b1010,
		S_NOALARM = 4'b1011,
		S_DROP    = 4'b1100,
		S_REPLAY  = 4'b1101
	} state_t;
endpackage : voice_alarm_pkg

// ---- rtl/voice_alarm_sequencer.sv ----
// Dial-out and dial-in voice alarm sequencer with an APB register slave.
//
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/10ps
`include "voice_alarm_params.svh"
module voice_alarm_sequencer #(
	parameter int          N_DIN       = 4,
	parameter logic [31:0] HOLD_CYCLES = 32'(`HOLD_TIME_S * `CLK_HZ),
	parameter logic [31:0] DROP_CYCLES = 32'(`DROP_TIME_S * `CLK_HZ)
) (
	input  wire logic               sys_clk,
	input  wire logic               rst,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [7:0]         paddr,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	input  wire logic               trigger_input,
	input  wire logic [N_DIN-1:0]   din_trigger_input,
	input  wire logic               incoming_call,
	input  wire logic               ring,
	input  wire logic               answered,
	input  wire logic               remote_hangup,
	input  wire logic               play_done,
	input  wire logic               key_valid,
	input  wire logic [3:0]         key_code,
	output logic                    call_success_output,
	output logic                    call_failure_output,
	output logic                    dial_req,
	output logic                    off_hook,
	output logic                    play_req,
	output logic      [7:0]         play_msg,
	output logic      [127:0]       phone_number
);
	import voice_alarm_pkg::*;

	localparam int IW = $clog2(N_DIN) + 1;

	typedef struct packed {
		state_t                  state;
		state_t                  after_play;
		logic                    dir_in;
		logic                    call_ok;
		logic                    remote_gone;
		logic [3:0]              attempts;
		logic [3:0]              rings;
		logic [3:0]              wrong;
		logic                    pw_armed;
		logic [1:0]              pw_cnt;
		logic [15:0]             pw_buf;
		logic [N_DIN-1:0]        sel;
		logic [IW-1:0]           idx;
		logic [1:0]              reps;
		logic [31:0]             timer;
		logic                    succ;
		logic                    fail;
		logic [N_DIN-1:0]        din_act;
		logic                    dial_req;
		logic                    off_hook;
		logic                    play_req;
		logic [7:0]              play_msg;
		logic                    pready;
		logic                    pslverr;
		logic [31:0]             prdata;
		logic [31:0]             ctrl;
		logic [7:0]              alarm_msg;
		logic [15:0]             password;
		logic [N_DIN-1:0][7:0]   din_cfg;
		logic [15:0][7:0]        phone;
	} regs_t;

	regs_t s;
	regs_t next_s;

	logic [N_DIN-1:0] free_mask;
	logic [N_DIN-1:0] prot_mask;
	logic [N_DIN-1:0] prot_cfg;
	logic             number_valid;
	logic             hit;
	logic [IW-1:0]    hit_idx;
	logic [7:0]       entry_msg;

	// Per entry protection flag.
	genvar g;
	generate
		for (g = 0; g < N_DIN; g++) begin : g_prot
			assign prot_cfg[g] = s.din_cfg[g][7];
		end
	endgenerate

	assign free_mask = s.din_act & ~prot_cfg;
	assign prot_mask = s.din_act & prot_cfg;

	// Number is valid only when a colon terminates it.
	always_comb begin
		number_valid = 1'b0;
		for (int i = 0; i < 16; i++) begin
			if (s.phone[i] == `PHONE_COLON) begin
				number_valid = 1'b1;
			end
		end
	end

	// Lowest selected entry at or above the current index.
	always_comb begin
		hit = 1'b0;
		hit_idx = '0;
		for (int i = N_DIN - 1; i >= 0; i--) begin
			if (s.sel[i] && (IW'(i) >= s.idx)) begin
				hit = 1'b1;
				hit_idx = IW'(i);
			end
		end
		entry_msg = s.dir_in ? {1'b0, s.din_cfg[hit_idx[IW-2:0]][6:0]} : s.alarm_msg;
	end

	always_comb begin
		next_s = s;
		next_s.dial_req = 1'b0;
		next_s.pready = 1'b0;
		next_s.pslverr = 1'b0;
		next_s.din_act = din_trigger_input;

		// APB slave: answer one cycle into the access phase.
		if (psel && penable && !s.pready) begin
			next_s.pready = 1'b1;
			next_s.prdata = '0;
			if (paddr[7:6] == `REG_PHONE_BASE) begin
				next_s.prdata = {24'h000000, s.phone[paddr[5:2]]};
			end else if (paddr == `REG_CTRL) begin
				next_s.prdata = s.ctrl;
			end else if (paddr == `REG_ALARM_MSG) begin
				next_s.prdata = {24'h000000, s.alarm_msg};
			end else if (paddr == `REG_PASSWORD) begin
				next_s.prdata = {16'h0000, s.password};
			end else if (paddr == `REG_STATUS) begin
				next_s.prdata = 32'({s.din_act, s.attempts, s.state, s.fail, s.succ, ~number_valid});
			end else if (paddr == `REG_DIN_CFG) begin
				next_s.prdata = 32'(s.din_cfg);
			end else begin
				next_s.pslverr = 1'b1;
			end
		end
		if (psel && penable && s.pready && pwrite && !s.pslverr) begin
			if (paddr[7:6] == `REG_PHONE_BASE) begin
				next_s.phone[paddr[5:2]] = pwdata[7:0];
			end else if (paddr == `REG_CTRL) begin
				next_s.ctrl = pwdata;
			end else if (paddr == `REG_ALARM_MSG) begin
				if (pwdata[7:0] >= `MSG_FIRST_USER) begin
					next_s.alarm_msg = pwdata[7:0];
				end
			end else if (paddr == `REG_PASSWORD) begin
				next_s.password = pwdata[15:0];
			end else if (paddr == `REG_DIN_CFG) begin
				for (int i = 0; i < N_DIN; i++) begin
					if (pwdata[i*8 +: 7] >= 7'(`MSG_FIRST_USER)) begin
						next_s.din_cfg[i] = pwdata[i*8 +: 8];
					end
				end
			end
		end

		if (s.off_hook && remote_hangup) begin
			next_s.remote_gone = 1'b1;
		end

		case (s.state)
			S_IDLE: begin
				next_s.off_hook = 1'b0;
				next_s.remote_gone = 1'b0;
				if (trigger_input && !s.succ && !s.fail) begin
					if (number_valid) begin
						next_s.state = S_DIAL;
						next_s.dir_in = 1'b0;
						next_s.attempts = '0;
						next_s.call_ok = 1'b0;
					end else begin
						next_s.fail = 1'b1;
					end
				end else if (incoming_call) begin
					next_s.off_hook = 1'b1;
					next_s.dir_in = 1'b1;
					next_s.idx = '0;
					if (s.din_act == '0) begin
						next_s.state = S_NOALARM;
					end else if (free_mask != '0) begin
						next_s.state = S_PLAY;
						next_s.sel = free_mask;
						next_s.reps = (prot_mask == '0) ? `ALARM_REPS : 2'd1;
						next_s.after_play = (prot_mask == '0) ? S_HOLD : S_PROMPT;
					end else begin
						next_s.state = S_PROMPT;
					end
				end
			end
			S_DIAL: begin
				next_s.dial_req = 1'b1;
				next_s.off_hook = 1'b1;
				next_s.attempts = s.attempts + 4'd1;
				next_s.rings = '0;
				next_s.wrong = '0;
				next_s.remote_gone = 1'b0;
				next_s.state = S_RING;
			end
			S_RING: begin
				if (answered) begin
					next_s.state = S_GREET;
				end else if (ring) begin
					next_s.rings = s.rings + 4'd1;
					if (s.rings + 4'd1 >= s.ctrl[`CTRL_RING_LSB +: 4]) begin
						next_s.state = S_END;
					end
				end
			end
			S_GETPW: begin
				if (s.remote_gone) begin
					next_s.state = S_DROP;
				end else if (key_valid && key_code == `KEY_STAR) begin
					next_s.pw_armed = 1'b1;
					next_s.pw_cnt = '0;
					next_s.pw_buf = '0;
				end else if (key_valid && s.pw_armed && key_code <= `KEY_LAST_DIGIT) begin
					next_s.pw_buf = {s.pw_buf[11:0], key_code};
					next_s.pw_cnt = s.pw_cnt + 2'd1;
					if (s.pw_cnt == 2'd3) begin
						next_s.pw_armed = 1'b0;
						if ({s.pw_buf[11:0], key_code} == s.password) begin
							next_s.state = S_PWOK;
						end else begin
							next_s.wrong = s.wrong + 4'd1;
							if (!s.dir_in && s.wrong + 4'd1 >= s.ctrl[`CTRL_WRONG_LSB +: 4]) begin
								next_s.state = S_END;
							end else begin
								next_s.state = S_PWBAD;
							end
						end
					end
				end
			end
			S_PLAY: begin
				if (!s.play_req) begin
					if (hit) begin
						next_s.play_req = 1'b1;
						next_s.play_msg = entry_msg;
						next_s.idx = hit_idx;
					end else if (s.reps > 2'd1) begin
						next_s.reps = s.reps - 2'd1;
						next_s.idx = '0;
					end else begin
						next_s.state = s.after_play;
						next_s.call_ok = !s.dir_in;
					end
				end else if (play_done) begin
					next_s.play_req = 1'b0;
					next_s.idx = s.idx + IW'(1);
					if (s.remote_gone) begin
						next_s.state = S_DROP;
					end
				end
			end
			S_REPLAY: begin
				next_s.sel = s.din_act;
				next_s.idx = '0;
				next_s.reps = `REPLAY_REPS;
				next_s.after_play = S_HOLD;
				next_s.state = S_PLAY;
			end
			S_HOLD, S_DROP: begin
				next_s.timer = s.timer - 32'd1;
				if (s.timer == '0) begin
					next_s.state = S_END;
				end
			end
			S_END: begin
				next_s.off_hook = 1'b0;
				next_s.state = S_IDLE;
				if (!s.dir_in) begin
					if (s.call_ok) begin
						next_s.succ = 1'b1;
					end else if (s.attempts < s.ctrl[`CTRL_ATT_LSB +: 4]) begin
						next_s.state = S_DIAL;
					end else begin
						next_s.fail = 1'b1;
					end
				end
			end
			default: begin
				// Single system message states: play once, then move on.
				if (!s.play_req) begin
					next_s.play_req = 1'b1;
					case (s.state)
						S_GREET:  next_s.play_msg = `MSG_PRESS0;
						S_PROMPT: next_s.play_msg = `MSG_PW_PROMPT;
						S_PWBAD:  next_s.play_msg = `MSG_PW_BAD;
						S_PWOK:   next_s.play_msg = `MSG_PW_OK;
						default:  next_s.play_msg = `MSG_NO_ALARM;
					endcase
				end else if (play_done) begin
					next_s.play_req = 1'b0;
					next_s.idx = '0;
					if (s.remote_gone) begin
						next_s.state = S_DROP;
					end else begin
						case (s.state)
							S_GREET: begin
								next_s.state = s.ctrl[`CTRL_PW_BIT] ? S_PROMPT : S_PLAY;
								next_s.sel = N_DIN'(1);
								next_s.reps = `ALARM_REPS;
								next_s.after_play = S_HOLD;
							end
							S_PROMPT: next_s.state = S_GETPW;
							S_PWBAD:  next_s.state = S_PROMPT;
							S_PWOK: begin
								next_s.state = S_PLAY;
								next_s.sel = s.dir_in ? prot_mask : N_DIN'(1);
								next_s.reps = (s.dir_in && free_mask != '0) ? 2'd1 : `ALARM_REPS;
								next_s.after_play = (s.dir_in && free_mask != '0) ? S_REPLAY : S_HOLD;
							end
							default:  next_s.state = S_HOLD;
						endcase
					end
				end
			end
		endcase

		if (next_s.state == S_HOLD && s.state != S_HOLD) begin
			next_s.timer = HOLD_CYCLES - 32'd1;
		end
		if (next_s.state == S_DROP && s.state != S_DROP) begin
			next_s.timer = DROP_CYCLES - 32'd1;
		end
		// Results clear together once the trigger drops.
		if (!trigger_input) begin
			next_s.succ = 1'b0;
			next_s.fail = 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s <= '0;
			s.state <= S_IDLE;
			s.after_play <= S_IDLE;
			s.ctrl <= `CTRL_RST;
			s.alarm_msg <= `ALARM_MSG_RST;
			s.password <= `PASSWORD_RST;
			s.din_cfg <= {N_DIN{`DIN_BYTE_RST}};
		end else begin
			s <= next_s;
		end
	end

	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign call_success_output = s.succ;
	assign call_failure_output = s.fail;
	assign dial_req = s.dial_req;
	assign off_hook = s.off_hook;
	assign play_req = s.play_req;
	assign play_msg = s.play_msg;
	assign phone_number = s.phone;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_result_exclusive: assert property (!(call_success_output && call_failure_output))
		else $error("success and failure both high");
	a_clear_on_low: assert property (!trigger_input |=> !call_success_output && !call_failure_output)
		else $error("result not cleared after trigger low");
	a_dial_start: assert property (s.state == S_IDLE && trigger_input && !s.succ && !s.fail && number_valid |-> ##2 dial_req)
		else $error("dial did not start");
	a_attempt_limit: assert property (dial_req |-> s.attempts <= s.ctrl[`CTRL_ATT_LSB +: 4])
		else $error("too many dial attempts");
	a_no_sysmsg: assert property (s.state == S_PLAY && play_req |-> play_msg >= `MSG_FIRST_USER)
		else $error("system message used as alarm");
	a_success_cause: assert property ($rose(call_success_output) |-> $past(s.call_ok) && $past(s.state) == S_END)
		else $error("success without completed call");
	a_hold_ends: assert property (s.state == S_HOLD && s.timer == 32'd0 |=> s.state == S_END)
		else $error("hold did not end");
	a_noalarm_msg: assert property (s.state == S_NOALARM && play_req |-> play_msg == `MSG_NO_ALARM)
		else $error("wrong no-alarm message");
	a_star_arm: assert property ($rose(s.pw_armed) |-> $past(key_valid) && $past(key_code) == `KEY_STAR)
		else $error("password armed without star");
	a_bad_pw_msg: assert property (s.state == S_PWBAD && play_req |-> play_msg == `MSG_PW_BAD)
		else $error("wrong password message missing");
	a_dial_valid: assert property (dial_req |-> number_valid)
		else $error("dialled an unterminated number");
	a_din_active: assert property ($rose(din_trigger_input[0]) |=> s.din_act[0])
		else $error("dial-in entry not activated");

	c_success: cover property ($rose(call_success_output));
	c_failure: cover property ($rose(call_failure_output));
	c_noalarm: cover property (s.state == S_NOALARM && play_req);
	c_replay: cover property (s.state == S_REPLAY);
endmodule : voice_alarm_sequencer

// ---- testbench/voice_line_model.sv ----
// Behavioural telephone line, caller keypad and voice player facing the sequencer.
`timescale 1ns/10ps
`include "voice_alarm_params.svh"
module voice_line_model (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        dial_req,
	input  wire logic        off_hook,
	input  wire logic        play_req,
	input  wire logic [7:0]  play_msg,
	input  wire logic [3:0]  answer_rings,
	input  wire logic [15:0] typed_pw,
	output logic             ring,
	output logic             answered,
	output logic             play_done,
	output logic             key_valid,
	output logic [3:0]       key_code
);
	logic [7:0] log_q[$];
	int         n_dials = 0;
	int         tick = 0, rcnt = 0, pcnt = 0, kcnt = 0;
	bit         ringing = 0, busy = 0, guard = 0;
	logic [7:0] cur = 8'h00;
	realtime    last_done = 0;
	always @(posedge sys_clk) begin
		{ring, answered, play_done, key_valid} <= '0;
		key_code <= rst ? 4'h0 : ~key_code;
		if (rst) begin
			{ringing, busy, guard} = '0;
			kcnt = 0;
		end else begin
			if (dial_req) begin
				n_dials++;
				ringing = 1;
				rcnt = 0;
				tick = 0;
			end else if (ringing && off_hook) begin
				tick++;
				if (tick % 4 == 0) begin
					rcnt++;
					ringing = (rcnt != answer_rings);
					if (ringing) ring <= 1'b1;
					else answered <= 1'b1;
				end
			end else ringing = 0;
			// A finished message is followed by one quiet cycle so the next request is seen fresh.
			if (busy) pcnt++;
			if (guard) guard = 0;
			else if (busy && pcnt == 6) begin
				play_done <= 1'b1;
				last_done = $realtime;
				busy = 0;
				guard = 1;
				if (cur == `MSG_PW_PROMPT) kcnt = 1;
			end else if (!busy && play_req) begin
				busy = 1;
				pcnt = 0;
				cur = play_msg;
				log_q.push_back(play_msg);
			end
			if (kcnt > 0) begin
				kcnt++;
				if (kcnt >= 4 && kcnt % 2 == 0) begin
					key_valid <= 1'b1;
					key_code <= (kcnt == 4) ? `KEY_STAR : typed_pw[15 - 2 * (kcnt - 6) -: 4];
				end
				if (kcnt == 12) kcnt = 0;
			end
		end
	end
endmodule : voice_line_model

// ---- testbench/tb_telephone_voice_alarm_sequencer.sv ----
// Self-checking bench for the voice alarm sequencer, driving APB and the line model.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
	$display("unexpected %s: expected %0h seen %0h", nm, e, g); end end
module tb_telephone_voice_alarm_sequencer;
	logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00, play_msg;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, er, trigger_input = 0, incoming_call = 0, remote_hangup = 0;
	logic [3:0] din_trigger_input = 4'h0, key_code, rings = 4'h0;
	logic [15:0] typed_pw = 16'h1234;
	logic ring, answered, play_done, key_valid, call_success_output, call_failure_output;
	logic dial_req, off_hook, play_req;
	logic [127:0] phone_number;
	int mismatches = 0, samples_checked = 0, ncyc, d0;
	always #4 sys_clk = ~sys_clk;
	voice_alarm_sequencer #(.N_DIN(4), .HOLD_CYCLES(32'd50), .DROP_CYCLES(32'd20)) DUT (
		.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.trigger_input(trigger_input), .din_trigger_input(din_trigger_input),
		.incoming_call(incoming_call), .ring(ring), .answered(answered),
		.remote_hangup(remote_hangup), .play_done(play_done), .key_valid(key_valid),
		.key_code(key_code), .call_success_output(call_success_output),
		.call_failure_output(call_failure_output), .dial_req(dial_req), .off_hook(off_hook),
		.play_req(play_req), .play_msg(play_msg), .phone_number(phone_number));
	voice_line_model m (
		.sys_clk(sys_clk), .rst(rst), .dial_req(dial_req), .off_hook(off_hook),
		.play_req(play_req), .play_msg(play_msg), .answer_rings(rings), .typed_pw(typed_pw),
		.ring(ring), .answered(answered), .play_done(play_done), .key_valid(key_valid),
		.key_code(key_code));
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'b00;
	endtask : apb
	task wait_until(input int k, input int n);
		ncyc = 0;
		do begin
			@(posedge sys_clk);
			ncyc++;
		end while (!(k == 0 ? (call_success_output | call_failure_output) === 1'b1 :
			k == 1 ? off_hook === 1'b0 : m.log_q.size() >= n) && ncyc < 4000);
		if (ncyc >= 4000) begin
			mismatches++;
			$display("unexpected wait %0d: expected done seen hang", k);
		end
	endtask : wait_until
	task set_trig(input logic v);
		@(posedge sys_clk);
		trigger_input <= v;
	endtask : set_trig
	task call_in(input logic [3:0] act);
		m.log_q.delete();
		@(posedge sys_clk);
		din_trigger_input <= act;
		@(posedge sys_clk);
		incoming_call <= 1'b1;
		@(posedge sys_clk);
		incoming_call <= 1'b0;
		wait_until(2, 1);
		wait_until(1, 0);
	endtask : call_in
	function automatic logic [63:0] logw();
		logic [63:0] r = {8'(m.log_q.size()), 56'h0};
		foreach (m.log_q[i]) if (i < 7) r[55:0] = {r[47:0], m.log_q[i]};
		return r;
	endfunction : logw
	function automatic int cnt(input logic [7:0] v);
		cnt = 0;
		foreach (m.log_q[i]) if (m.log_q[i] === v) cnt++;
	endfunction : cnt
	task test_done;
		$display("compared %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : test_done
	initial begin
		repeat (40000) @(posedge sys_clk);
		mismatches++;
		test_done();
	end
	initial begin
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		apb(0, 8'h00, 0);
		`CHK("ctrl", 32'h0003_5300, rd)
		apb(0, 8'h10, 0);
		`CHK("din cfg", 32'h0505_0505, rd)
		apb(1, 8'h20, 32'h1);
		`CHK("unmapped", 1'b1, er)
		set_trig(1);
		wait_until(0, 0);
		repeat (10) @(posedge sys_clk);
		`CHK("no colon", 2'b10, {call_failure_output, call_success_output})
		`CHK("no dial", 0, m.n_dials)
		set_trig(0);
		repeat (2) @(posedge sys_clk);
		`CHK("released", 2'b00, {call_failure_output, call_success_output})
		apb(1, 8'h40, 32'h31);
		apb(1, 8'h44, 32'h32);
		apb(1, 8'h48, 32'h3a);
		apb(1, 8'h4c, 32'h39);
		`CHK("number", 24'h3a3231, phone_number[23:0])
		apb(1, 8'h00, 32'h0003_2200);
		set_trig(1);
		wait_until(0, 0);
		`CHK("no answer", 2'b10, {call_failure_output, call_success_output})
		`CHK("dials", 2, m.n_dials)
		set_trig(0);
		apb(1, 8'h04, 32'h03);
		apb(0, 8'h04, 0);
		`CHK("sys msg", 32'h05, rd)
		apb(1, 8'h04, 32'h09);
		rings <= 4'h2;
		m.log_q.delete();
		set_trig(1);
		wait_until(0, 0);
		`CHK("no pw log", 64'h04_000000_00090909, logw())
		`CHK("hold", 1'b1, int'(($realtime - m.last_done) / 8) inside {[50 : 60]})
		repeat (10) @(posedge sys_clk);
		`CHK("no pw ok", 2'b01, {call_failure_output, call_success_output})
		set_trig(0);
		repeat (2) @(posedge sys_clk);
		`CHK("cleared", 2'b00, {call_failure_output, call_success_output})
		apb(1, 8'h00, 32'h0003_2201);
		m.log_q.delete();
		set_trig(1);
		wait_until(0, 0);
		`CHK("pw log", 64'h06_0000_0102_0909_09, logw())
		`CHK("pw ok", 2'b01, {call_failure_output, call_success_output})
		set_trig(0);
		typed_pw <= 16'h9999;
		m.log_q.delete();
		d0 = m.n_dials;
		set_trig(1);
		wait_until(0, 0);
		`CHK("bad pw", 2'b10, {call_failure_output, call_success_output})
		`CHK("redials", 2, m.n_dials - d0)
		`CHK("prompts", 6, cnt(8'h01))
		`CHK("no confirm", 0, cnt(8'h02))
		set_trig(0);
		typed_pw <= 16'h1234;
		apb(1, 8'h00, 32'h0003_2200);
		m.log_q.delete();
		set_trig(1);
		wait_until(2, 2);
		remote_hangup <= 1'b1;
		@(posedge sys_clk);
		remote_hangup <= 1'b0;
		rings <= 4'h0;
		wait_until(1, 0);
		`CHK("drop delay", 1'b1, ncyc inside {[20 : 40]})
		`CHK("drop log", 2, m.log_q.size())
		set_trig(0);
		repeat (300) @(posedge sys_clk);
		apb(0, 8'h0c, 0);
		`CHK("idle", 4'h0, rd[6:3])
		call_in(4'h0);
		`CHK("no alarm", 64'h01_000000_00000004, logw())
		apb(1, 8'h10, 32'h0908_0706);
		call_in(4'b0101);
		`CHK("free 6", 3, cnt(8'h06))
		`CHK("free 8", 3, cnt(8'h08))
		`CHK("free n", 6, m.log_q.size())
		apb(1, 8'h10, 32'h0908_0786);
		call_in(4'b0011);
		`CHK("mix head", 32'h0701_0206, {m.log_q[0], m.log_q[1], m.log_q[2], m.log_q[3]})
		`CHK("mix 6", 3, cnt(8'h06))
		`CHK("mix 7", 3, cnt(8'h07))
		test_done();
	end
endmodule : tb_telephone_voice_alarm_sequencer
